// [rtl/mss_regs.svh]
// mss_regs.svh: register offsets, field positions, reset values and timing
// assumes: included by the sequencer design files only
`ifndef MSS_REGS_SVH
`define MSS_REGS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MSS_CTRL_OFS 8'h00
`define MSS_SS_CFG_OFS 8'h04
`define MSS_KICK_CFG_OFS 8'h08
`define MSS_LIMIT_OFS 8'h0C
`define MSS_STATUS_OFS 8'h10
`define MSS_IRQ_STAT_OFS 8'h14
`define MSS_IRQ_MASK_OFS 8'h18
`define MSS_ELAPSED_OFS 8'h1C
// ----------------------------------------------------------------
// ctrl fields
// ----------------------------------------------------------------
`define MSS_CTRL_FVM_BIT 0
`define MSS_CTRL_TERM_BIT 1
`define MSS_CTRL_STOPSEL_LSB 4
`define MSS_CTRL_RESET 32'h0000_0002
// ----------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------
`define MSS_IRQ_RUN_BIT 0
`define MSS_IRQ_STOP_BIT 1
`define MSS_IRQ_SS_BIT 2
`define MSS_IRQ_LIMIT_BIT 3
`define MSS_IRQ_SPEED_BIT 4
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MSS_CLK_MHZ 200
`define MSS_TICK_US 100
`define MSS_TICK_CYC (`MSS_TICK_US * `MSS_CLK_MHZ)
`endif

// [rtl/mss_pkg.sv]
// mss_pkg.sv: types shared by the sequencer files
// assumes: nothing
package mss_pkg;
  typedef enum logic [2:0] {
    MSS_IDLE = 3'b000,
    MSS_RUN = 3'b001,
    MSS_SS_KICK = 3'b010,
    MSS_SS_RUN = 3'b011
  } mss_state_e;
  typedef struct packed {
    logic start;
    logic ss_fwd;
    logic ss_rev;
    logic at_speed;
    logic [3:0] di;
  } mss_pins_s;
  typedef struct packed {
    logic run_relay;
    logic at_speed_relay;
    logic ss_relay;
    logic ss_dir_rev;
    logic gate_en;
    logic [7:0] current_ref;
  } mss_drive_s;
endpackage : mss_pkg

// [rtl/mss_sync.sv]
// mss_sync.sv: two-flop synchroniser for a bundle of pin levels
// assumes: inputs are asynchronous levels
`timescale 1ns/10ps
module mss_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire mss_pkg::mss_pins_s pins_in,
  output mss_pkg::mss_pins_s pins_out
);
  import mss_pkg::*;
  mss_pins_s meta;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= '0;
      pins_out <= '0;
    end else begin
      meta <= pins_in;
      pins_out <= meta;
    end
  end
endmodule : mss_sync

// [rtl/mss_sequencer.sv]
// mss_sequencer.sv: start/stop and slow-speed sequencer, avalon slave
// assumes: 200 MHz clk_in, pins asynchronous, avalon master on same clock
//
// How it works
// - kick time counts toward the slow-speed time limit
// - slow-speed elapsed timer clears whenever the motor is stopped
// - kick level off skips kick and goes straight to slow level
// - slow speed applies kick level for kick time, then slow level
// - full-voltage mode: start energizes the run relay and contactor
// - full-voltage mode: at-speed decision energizes at-speed relay
// - full-voltage mode suppresses thyristor and stack overload faults
// - full-voltage mode ignores ramp, kick and decel settings
// - full-voltage mode keeps all thyristor gate drives off
// - 2-wire: run while start high, stop when it drops
// - 3-wire: latch on start pulse, run until a stop input low
// - start rising edge with stop input high picks 3-wire
// - slow-speed request only when idle, terminal source, direction input
// - slow-speed time limited; limit 0 disables the limit, elapsed still counts
`timescale 1ns/10ps
`include "mss_regs.svh"
module mss_sequencer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire mss_pkg::mss_pins_s pins_in,
  output mss_pkg::mss_drive_s drive_out,
  output logic stack_prot_en_out,
  output logic irq_out
);
  import mss_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mss_state_e st;
    logic three_wire;
    logic start_d;
    logic ss_hold;
    logic [31:0] ctrl;
    logic [31:0] ss_cfg;
    logic [31:0] kick_cfg;
    logic [15:0] limit;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;
    logic [15:0] tick_cnt;
    logic [15:0] elapsed;
    logic [15:0] kick_left;
    logic ack;
    logic wait_req;
    logic [31:0] rdata;
    mss_drive_s drv;
    logic stack_prot;
    logic irq;
  } mss_regs_s;

  mss_regs_s r;
  mss_regs_s next_r;
  mss_pins_s pins;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  mss_sync u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pins_in(pins_in),
    .pins_out(pins)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-enable merge, used by ctrl, ss_cfg, kick_cfg and limit
  function automatic logic [31:0] mss_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : mss_merge

  // 2-wire follows the start level, 3-wire waits for a selected stop low
  function automatic logic mss_stop_now(input logic three,
      input logic stop_lo, input logic start);
    logic res;
    res = three ? stop_lo : !start;
    return res;
  endfunction : mss_stop_now

  // ----------------------------------------------------------------
  // decoded settings and pin views
  // ----------------------------------------------------------------
  logic fvm;
  logic term_src;
  logic [3:0] stop_sel;
  logic stop_high;
  logic stop_low;
  logic start_rise;
  logic [7:0] ss_level;
  logic [7:0] kick_level;
  logic [15:0] kick_time;
  logic tick;
  logic limit_hit;
  logic [4:0] ev;
  logic [31:0] wmerged;
  logic acc;
  logic take_wr;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    fvm = r.ctrl[`MSS_CTRL_FVM_BIT];
    term_src = r.ctrl[`MSS_CTRL_TERM_BIT];
    stop_sel = r.ctrl[`MSS_CTRL_STOPSEL_LSB +: 4];
    // a stop input is any di selected as stop
    stop_high = |(stop_sel & pins.di);
    stop_low = |(stop_sel & ~pins.di);
    start_rise = pins.start & ~r.start_d;
    ss_level = r.ss_cfg[7:0];
    kick_level = r.kick_cfg[7:0];
    kick_time = r.kick_cfg[31:16];
    tick = (r.tick_cnt == 16'(`MSS_TICK_CYC - 1));
    limit_hit = (r.limit != 16'h0000) && (r.elapsed >= r.limit);
    acc = (avs_read_in | avs_write_in) & ~r.ack;
    // writes land at the edge that sees waitrequest low
    take_wr = avs_write_in & r.ack;
    wmerged = 32'h0000_0000;
    unique case (avs_address_in)
      `MSS_CTRL_OFS: wmerged = mss_merge(r.ctrl, avs_writedata_in,
        avs_byteenable_in);
      `MSS_SS_CFG_OFS: wmerged = mss_merge(r.ss_cfg, avs_writedata_in,
        avs_byteenable_in);
      `MSS_KICK_CFG_OFS: wmerged = mss_merge(r.kick_cfg, avs_writedata_in,
        avs_byteenable_in);
      `MSS_LIMIT_OFS: wmerged = mss_merge({16'h0000, r.limit},
        avs_writedata_in, avs_byteenable_in);
      default: wmerged = avs_writedata_in & {{8{avs_byteenable_in[3]}},
        {8{avs_byteenable_in[2]}}, {8{avs_byteenable_in[1]}},
        {8{avs_byteenable_in[0]}}};
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    ev = 5'b00000;
    next_r.start_d = pins.start;
    next_r.tick_cnt = tick ? 16'h0000 : r.tick_cnt + 16'h0001;
    // a slow-speed request must drop before a new one is taken
    if (!(pins.ss_fwd | pins.ss_rev)) begin
      next_r.ss_hold = 1'b0;
    end
    unique case (r.st)
      MSS_IDLE: begin
        next_r.elapsed = 16'h0000;
        // restart the tick phase so kick and limit time from entry
        next_r.tick_cnt = 16'h0000;
        // start beats a slow-speed request seen in the same cycle
        if (start_rise) begin
          next_r.three_wire = stop_high;
          next_r.st = MSS_RUN;
          ev[`MSS_IRQ_RUN_BIT] = 1'b1;
        end else if ((pins.ss_fwd | pins.ss_rev) && term_src && !fvm
            && ss_level != 8'h00 && !r.ss_hold) begin
          next_r.drv.ss_dir_rev = pins.ss_rev & ~pins.ss_fwd;
          next_r.kick_left = kick_time;
          ev[`MSS_IRQ_SS_BIT] = 1'b1;
          if (kick_level == 8'h00 || kick_time == 16'h0000) begin
            next_r.st = MSS_SS_RUN;
          end else begin
            next_r.st = MSS_SS_KICK;
          end
        end
      end
      MSS_RUN: begin
        if (mss_stop_now(r.three_wire, stop_low, pins.start)) begin
          next_r.st = MSS_IDLE;
          ev[`MSS_IRQ_STOP_BIT] = 1'b1;
        end
      end
      MSS_SS_KICK, MSS_SS_RUN: begin
        if (tick && r.elapsed != 16'hFFFF) begin
          next_r.elapsed = r.elapsed + 16'h0001;
        end
        if (r.st == MSS_SS_KICK && tick) begin
          next_r.kick_left = r.kick_left - 16'h0001;
          if (r.kick_left == 16'h0001) begin
            next_r.st = MSS_SS_RUN;
          end
        end
        // the limit wins over a dropped direction input
        if (limit_hit) begin
          next_r.st = MSS_IDLE;
          // a request still held must not restart slow speed at once
          next_r.ss_hold = 1'b1;
          ev[`MSS_IRQ_LIMIT_BIT] = 1'b1;
        end else if (!(pins.ss_fwd | pins.ss_rev)) begin
          next_r.st = MSS_IDLE;
          ev[`MSS_IRQ_STOP_BIT] = 1'b1;
        end
      end
      default: next_r.st = MSS_IDLE;
    endcase
    // ----------------------------------------------------------------
    // relay, gate and current outputs
    // ----------------------------------------------------------------
    // drive outputs from the next state so they leave one flop
    next_r.drv.run_relay = (next_r.st == MSS_RUN);
    next_r.drv.at_speed_relay = (next_r.st == MSS_RUN) && pins.at_speed;
    if (next_r.drv.at_speed_relay && !r.drv.at_speed_relay) begin
      ev[`MSS_IRQ_SPEED_BIT] = 1'b1;
    end
    next_r.drv.ss_relay = (next_r.st == MSS_SS_KICK)
      || (next_r.st == MSS_SS_RUN);
    // ramp and kick are soft-start features; contactor mode skips them
    next_r.drv.gate_en = !fvm && (next_r.st != MSS_IDLE);
    unique case (next_r.st)
      MSS_SS_KICK: next_r.drv.current_ref = kick_level;
      MSS_SS_RUN: next_r.drv.current_ref = ss_level;
      MSS_RUN: next_r.drv.current_ref = fvm ? 8'h00 : 8'hFF;
      default: next_r.drv.current_ref = 8'h00;
    endcase
    next_r.stack_prot = !fvm;
    // ----------------------------------------------------------------
    // bus slave: one wait cycle, answer on the second
    // ----------------------------------------------------------------
    next_r.ack = acc;
    // a flop, so waitrequest also stands high while the bus is idle
    next_r.wait_req = ~acc;
    next_r.rdata = 32'h0000_0000;
    if (acc && avs_read_in) begin
      unique case (avs_address_in)
        `MSS_CTRL_OFS: next_r.rdata = r.ctrl;
        `MSS_SS_CFG_OFS: next_r.rdata = r.ss_cfg;
        `MSS_KICK_CFG_OFS: next_r.rdata = r.kick_cfg;
        `MSS_LIMIT_OFS: next_r.rdata = {16'h0000, r.limit};
        `MSS_STATUS_OFS: next_r.rdata = {24'h0, r.three_wire, fvm,
          r.drv.at_speed_relay, 2'b00, r.st};
        `MSS_IRQ_STAT_OFS: next_r.rdata = {27'h0, r.irq_stat};
        `MSS_IRQ_MASK_OFS: next_r.rdata = {27'h0, r.irq_mask};
        `MSS_ELAPSED_OFS: next_r.rdata = {16'h0000, r.elapsed};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
    // ----------------------------------------------------------------
    // register writes and interrupt
    // ----------------------------------------------------------------
    next_r.irq_stat = r.irq_stat;
    if (take_wr) begin
      unique case (avs_address_in)
        `MSS_CTRL_OFS: next_r.ctrl = wmerged;
        `MSS_SS_CFG_OFS: next_r.ss_cfg = wmerged;
        `MSS_KICK_CFG_OFS: next_r.kick_cfg = wmerged;
        `MSS_LIMIT_OFS: next_r.limit = wmerged[15:0];
        `MSS_IRQ_STAT_OFS: next_r.irq_stat = r.irq_stat & ~wmerged[4:0];
        `MSS_IRQ_MASK_OFS: next_r.irq_mask = wmerged[4:0];
        default: next_r.limit = r.limit;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_r.irq_stat = next_r.irq_stat | ev;
    next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
      r.st <= MSS_IDLE;
      r.ctrl <= `MSS_CTRL_RESET;
      r.stack_prot <= 1'b1;
      r.wait_req <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign avs_readdata_out = r.rdata;
  assign avs_waitrequest_out = r.wait_req;
  assign drive_out = r.drv;
  assign stack_prot_en_out = r.stack_prot;
  assign irq_out = r.irq;
endmodule : mss_sequencer

// [verification/mss_sequencer_properties.sv]
// mss_sequencer_properties.sv: port checker for the sequencer
// assumes: bound to mss_sequencer, one clock domain
`timescale 1ns/10ps
module mss_sequencer_properties (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic avs_read_in,
  input wire logic avs_waitrequest_out,
  input wire mss_pkg::mss_pins_s pins_in,
  input wire mss_pkg::mss_drive_s drive_out,
  input wire logic stack_prot_en_out
);
  import mss_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_gate; !stack_prot_en_out |-> !drive_out.gate_en; endproperty
  a_gate: assert property (p_gate) else $error("gate on");
  // pins take up to three cycles through sync and decision
  property p_start; $rose(pins_in.start) && !drive_out.ss_relay
    ##1 pins_in.start [*5] |-> drive_out.run_relay; endproperty
  a_start: assert property (p_start) else $error("no run");
  property p_stop; (pins_in.di == 4'h0 && !pins_in.start) [*5]
    |-> !drive_out.run_relay; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_uts;
    $rose(drive_out.at_speed_relay) |-> drive_out.run_relay; endproperty
  a_uts: assert property (p_uts) else $error("uts idle");
  property p_idle; !drive_out.run_relay && !drive_out.ss_relay
    |-> drive_out.current_ref == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle current");
  property p_ss_idle;
    $rose(drive_out.ss_relay) |-> !$past(drive_out.run_relay); endproperty
  a_ss_idle: assert property (p_ss_idle) else $error("ss busy");
  property p_ss_cur;
    $rose(drive_out.ss_relay) |-> drive_out.current_ref != 8'h00; endproperty
  a_ss_cur: assert property (p_ss_cur) else $error("ss no current");
  property p_wait; $rose(avs_read_in)
    |-> avs_waitrequest_out ##1 !avs_waitrequest_out; endproperty
  a_wait: assert property (p_wait) else $error("wait state");
endmodule : mss_sequencer_properties
bind mss_sequencer mss_sequencer_properties i_chk (.clk_in(clk_in),
  .rst_in(rst_in), .avs_read_in(avs_read_in),
  .avs_waitrequest_out(avs_waitrequest_out), .pins_in(pins_in),
  .drive_out(drive_out), .stack_prot_en_out(stack_prot_en_out));

// [verification/mss_panel.sv]
// mss_panel.sv: pushbuttons, selector and contacts on the pins
// assumes: level inputs from the bench, nothing clocked
`timescale 1ns/10ps
module mss_panel (
  input wire logic hand_in,
  input wire logic cmd_in,
  input wire logic stop_in,
  input wire logic ss_in,
  input wire logic rev_in,
  input wire logic spd_in,
  output mss_pkg::mss_pins_s pins_out
);
  import mss_pkg::*;
  // in hand the stop contact sits ahead of start, so a held stop blocks start
  assign pins_out.start = cmd_in & ~(hand_in & stop_in);
  assign pins_out.di = {3'h0, hand_in & ~stop_in};
  assign pins_out.ss_fwd = ss_in & ~rev_in;
  assign pins_out.ss_rev = ss_in & rev_in;
  assign pins_out.at_speed = spd_in;
endmodule : mss_panel

// [verification/mss_sequencer_tb.sv]
// mss_sequencer_tb.sv: self-checking bench for the sequencer
// assumes: panel model on the pins, avalon master in this module
`timescale 1ns/10ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin \
  err_count++; $display("mismatch %s exp %0h got %0h", nm, e, a); end end
module mss_sequencer_tb;
  import mss_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rdout;
  logic wreq, irq, prot;
  logic hand = 1'b0, cmd = 1'b0, stp = 1'b0, ss = 1'b0, spd = 1'b0;
  logic rev = 1'b0;
  mss_pins_s pins;
  mss_drive_s drv;
  int err_count = 0;
  int check_count = 0;
  // {hand, start or contact, stop pressed, run expected}
  logic [3:0] rows [6] = '{4'h5, 4'h0, 4'hD, 4'h9, 4'hA, 4'h8};
  always #2.5 clk_in = ~clk_in;
  mss_panel i_panel (.hand_in(hand), .cmd_in(cmd), .stop_in(stp),
    .ss_in(ss), .rev_in(rev), .spd_in(spd), .pins_out(pins));
  mss_sequencer i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(adr), .avs_read_in(rd_en), .avs_write_in(wr_en),
    .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdout), .avs_waitrequest_out(wreq),
    .pins_in(pins), .drive_out(drv), .stack_prot_en_out(prot),
    .irq_out(irq));
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask : w
  // called just after a rising edge; request held until waitrequest is
  // seen low at a rising edge, then one idle edge before the next call
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    wr_en <= wr;
    rd_en <= !wr;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    rdata = rdout;
    if (n == 20) err_count++;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk_in);
  endtask : bus
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (80000) @(posedge clk_in);
    err_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    bus(0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h2, rdata)
    bus(0, 8'hFC, 32'h0);
    `CHK("unmapped", 32'h0, rdata)
    bus(1, 8'h00, 32'h12);
    foreach (rows[i]) begin
      {hand, cmd, stp} <= rows[i][3:1];
      w(8);
      `CHK("run", rows[i][0], drv.run_relay)
      `CHK("gate", rows[i][0], drv.gate_en)
    end
    // --------------------------------------------
    // reset in mid-run
    // --------------------------------------------
    {hand, cmd} <= 2'b01;
    w(8);
    `CHK("run", 1'b1, drv.run_relay)
    rst_in <= 1'b1;
    w(2);
    `CHK("rst run", 1'b0, drv.run_relay)
    `CHK("rst prot", 1'b1, prot)
    `CHK("rst irq", 1'b0, irq)
    rst_in <= 1'b0;
    cmd <= 1'b0;
    bus(0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h2, rdata)
    // --------------------------------------------
    // full voltage, then slow speed with limit
    // --------------------------------------------
    bus(1, 8'h00, 32'h13);
    {hand, cmd, spd} <= 3'b011;
    w(8);
    `CHK("run", 1'b1, drv.run_relay)
    `CHK("uts", 1'b1, drv.at_speed_relay)
    `CHK("gate", 1'b0, drv.gate_en)
    `CHK("prot", 1'b0, prot)
    `CHK("cur", 8'h00, drv.current_ref)
    {cmd, spd} <= 2'b00;
    w(8);
    bus(1, 8'h00, 32'h10);
    bus(1, 8'h04, 32'h20);
    bus(1, 8'h08, 32'h1_0050);
    bus(1, 8'h0C, 32'h3);
    bus(1, 8'h18, 32'h8);
    ss <= 1'b1;
    w(8);
    `CHK("ssr", 1'b0, drv.ss_relay)
    ss <= 1'b0;
    bus(1, 8'h00, 32'h12);
    ss <= 1'b1;
    w(8);
    `CHK("kick", 8'h50, drv.current_ref)
    `CHK("fwd", 1'b0, drv.ss_dir_rev)
    `CHK("ssr", 1'b1, drv.ss_relay)
    w(20100);
    `CHK("slow", 8'h20, drv.current_ref)
    w(39800);
    `CHK("ssr", 1'b1, drv.ss_relay)
    `CHK("irq", 1'b0, irq)
    w(200);
    `CHK("ssr", 1'b0, drv.ss_relay)
    `CHK("cur", 8'h00, drv.current_ref)
    `CHK("irq", 1'b1, irq)
    bus(1, 8'h14, 32'h8);
    w(3);
    `CHK("irq", 1'b0, irq)
    `CHK("held", 1'b0, drv.ss_relay)
    bus(0, 8'h1C, 32'h0);
    `CHK("elapsed", 32'h0, rdata)
    ss <= 1'b0;
    bus(1, 8'h08, 32'h1_0000);
    w(8);
    ss <= 1'b1;
    w(8);
    `CHK("slow", 8'h20, drv.current_ref)
    bus(0, 8'h1C, 32'h0);
    `CHK("elapsed", 32'h0, rdata)
    ss <= 1'b0;
    w(8);
    {ss, rev} <= 2'b11;
    w(8);
    `CHK("rev", 1'b1, drv.ss_dir_rev)
    ss <= 1'b0;
    stop_test();
  end
endmodule : mss_sequencer_tb
